// *** sbp_regs.vh ***
/*
 * constants for the basic flash parameter table slice (relative bytes 30h..40h).
 * assumes: included by sbp_param_rom.v only; no logic here.
 */
`ifndef SBP_REGS_VH
`define SBP_REGS_VH

// ------------------------------------------------------------
// table window
// ------------------------------------------------------------
`define SBP_ADDR_FIRST 8'h30
`define SBP_ADDR_LAST 8'h40
`define SBP_FILL_BYTE 8'hff

// ------------------------------------------------------------
// first parameter byte fields
// ------------------------------------------------------------
`define SBP_B30_UNUSED 3'b111
`define SBP_B30_STATUS_MODE 2'b00
`define SBP_B30_BIG_BUFFER 1'b1
`define SBP_B30_ERASE_4K 2'b01

// ------------------------------------------------------------
// byte 32h fields
// ------------------------------------------------------------
`define SBP_B32_UNUSED 1'b1
`define SBP_B32_QUAD_OUTPUT_READ 1'b1
`define SBP_B32_QUAD_IO_READ 1'b1
`define SBP_B32_DUAL_IO_READ 1'b1
`define SBP_B32_DTR 1'b0
`define SBP_B32_ADDR_BYTES 2'b00
`define SBP_B32_SINGLE_WIRE_READ 1'b1

// ------------------------------------------------------------
// byte 40h fields
// ------------------------------------------------------------
`define SBP_B40_RESERVED_BITS_HI 3'b111
`define SBP_B40_FOUR_WIRE_COMMAND_MODE 1'b0
`define SBP_B40_RESERVED_BITS_LO 3'b111
`define SBP_B40_DUAL_ALL 1'b0

// ------------------------------------------------------------
// whole byte values and read timing mode/dummy fields
// ------------------------------------------------------------
`define SBP_ERASE_4K_OPCODE 8'h20
`define SBP_UNUSED_31_24 8'hff
`define SBP_DENSITY_B0 8'hff
`define SBP_DENSITY_B1 8'hff
`define SBP_DENSITY_B2 8'hff
`define SBP_DENSITY_B3 8'h00
`define SBP_QUAD_IO_MODE 3'b010
`define SBP_QUAD_IO_DUMMY 5'b00100
`define SBP_QUAD_IO_OPCODE 8'heb
`define SBP_QUAD_OUT_MODE 3'b000
`define SBP_QUAD_OUT_DUMMY 5'b01000
`define SBP_QUAD_OUT_OPCODE 8'h6b
`define SBP_DOR_MODE 3'b000
`define SBP_DOR_DUMMY 5'b01000
`define SBP_DOR_OPCODE 8'h3b
`define SBP_DUAL_IO_MODE 3'b100
`define SBP_DUAL_IO_DUMMY 5'b00000
`define SBP_DUAL_IO_OPCODE 8'hbb

// ------------------------------------------------------------
// access command and register map
// ------------------------------------------------------------
`define SBP_READ_PARAM_OPCODE 8'h5a
`define SBP_REG_ADDR 4'h0
`define SBP_REG_DATA 4'h4
`define SBP_REG_CMD 4'h8
`define SBP_CMD_OK 8'h01
`define SBP_RESP_OKAY 2'b00
`define SBP_RESP_SLVERR 2'b10
`define SBP_RESP_DECERR 2'b11

`endif

// *** sbp_param_rom.v ***
/*
 * basic flash parameter table slice (relative bytes 30h..40h) with an
 * auto-incrementing byte reader, reached by an axi4-lite slave.
 * assumes: one clock aclk, synchronous active-low aresetn; the command
 * decoder that recognises the parameter read opcode sits outside and
 * mirrors it through the command register here.
 */
// Function
// - byte 30h reads e5h, top bits ones
// - byte 30h bits 1:0 read 01b
// - byte 30h bit 2 reads one
// - byte 30h bits 4:3 read 00b
// - byte 31h reads 20h erase opcode
// - byte 32h reads f1h, support flags
// - byte 32h dtr and address bits zero
// - byte 33h reads ffh
// - bytes 34h..37h read ff ff ff 00
// - byte 38h reads 44h quad io timing
// - byte 39h reads ebh
// - byte 3ah reads 08h quad output timing
// - byte 3bh reads 6bh
// - byte 3ch reads 08h dual output timing
// - byte 3dh reads 3bh
// - byte 3eh reads 80h dual io timing
// - byte 3fh reads bbh
// - byte 40h reads eeh
// - read opened by opcode 5ah, address zero
`timescale 1ns/1ns
`include "sbp_regs.vh"

module sbp_param_rom #(
    parameter ADDR_W = 8
) (
    input wire aclk,
    input wire aresetn,
    input wire [3:0] s_axi_awaddr,
    input wire s_axi_awvalid,
    output wire s_axi_awready,
    input wire [31:0] s_axi_wdata,
    input wire [3:0] s_axi_wstrb,
    input wire s_axi_wvalid,
    output wire s_axi_wready,
    output reg [1:0] s_axi_bresp,
    output reg s_axi_bvalid,
    input wire s_axi_bready,
    input wire [3:0] s_axi_araddr,
    input wire s_axi_arvalid,
    output wire s_axi_arready,
    output reg [31:0] s_axi_rdata,
    output reg [1:0] s_axi_rresp,
    output reg s_axi_rvalid,
    input wire s_axi_rready
);

// ------------------------------------------------------------
// table contents
// ------------------------------------------------------------
reg [ADDR_W-1:0] rd_addr;
reg [7:0] cmd_opcode;
reg [7:0] rom_byte;

always @* begin
    case (rd_addr)
        `SBP_ADDR_FIRST: rom_byte = {`SBP_B30_UNUSED,
                                      `SBP_B30_STATUS_MODE,
                                      `SBP_B30_BIG_BUFFER,
                                      `SBP_B30_ERASE_4K};
        8'h31: rom_byte = `SBP_ERASE_4K_OPCODE;
        8'h32: rom_byte = {`SBP_B32_UNUSED, `SBP_B32_QUAD_OUTPUT_READ,
                           `SBP_B32_QUAD_IO_READ, `SBP_B32_DUAL_IO_READ,
                           `SBP_B32_DTR, `SBP_B32_ADDR_BYTES,
                           `SBP_B32_SINGLE_WIRE_READ};
        8'h33: rom_byte = `SBP_UNUSED_31_24;
        8'h34: rom_byte = `SBP_DENSITY_B0;
        8'h35: rom_byte = `SBP_DENSITY_B1;
        8'h36: rom_byte = `SBP_DENSITY_B2;
        8'h37: rom_byte = `SBP_DENSITY_B3;
        8'h38: rom_byte = {`SBP_QUAD_IO_MODE, `SBP_QUAD_IO_DUMMY};
        8'h39: rom_byte = `SBP_QUAD_IO_OPCODE;
        8'h3a: rom_byte = {`SBP_QUAD_OUT_MODE, `SBP_QUAD_OUT_DUMMY};
        8'h3b: rom_byte = `SBP_QUAD_OUT_OPCODE;
        8'h3c: rom_byte = {`SBP_DOR_MODE, `SBP_DOR_DUMMY};
        8'h3d: rom_byte = `SBP_DOR_OPCODE;
        8'h3e: rom_byte = {`SBP_DUAL_IO_MODE, `SBP_DUAL_IO_DUMMY};
        8'h3f: rom_byte = `SBP_DUAL_IO_OPCODE;
        `SBP_ADDR_LAST: rom_byte = {`SBP_B40_RESERVED_BITS_HI,
                                    `SBP_B40_FOUR_WIRE_COMMAND_MODE,
                                    `SBP_B40_RESERVED_BITS_LO,
                                    `SBP_B40_DUAL_ALL};
        // bytes outside this slice belong to neighbouring tables
        default: rom_byte = `SBP_FILL_BYTE;
    endcase
end

// ------------------------------------------------------------
// write channel: aw and w taken in either order
// ------------------------------------------------------------
reg aw_held;
reg w_held;
reg [3:0] aw_addr;
reg [31:0] w_data;
reg [3:0] w_strb;

wire aw_fire = s_axi_awvalid & s_axi_awready;
wire w_fire = s_axi_wvalid & s_axi_wready;
wire [3:0] wr_addr = aw_held ? aw_addr : s_axi_awaddr;
wire [31:0] wr_data = w_held ? w_data : s_axi_wdata;
wire [3:0] wr_strb = w_held ? w_strb : s_axi_wstrb;
wire wr_go = (aw_held | aw_fire) & (w_held | w_fire) & ~s_axi_bvalid;

assign s_axi_awready = ~aw_held & ~s_axi_bvalid;
assign s_axi_wready = ~w_held & ~s_axi_bvalid;

wire wr_hit_addr = wr_addr == `SBP_REG_ADDR;
wire wr_hit_cmd = wr_addr == `SBP_REG_CMD;

always @(posedge aclk) begin
    if (!aresetn) begin
        aw_held <= 1'b0;
        w_held <= 1'b0;
        aw_addr <= 4'h0;
        w_data <= 32'h0000_0000;
        w_strb <= 4'h0;
        s_axi_bvalid <= 1'b0;
        s_axi_bresp <= `SBP_RESP_OKAY;
    end else begin
        if (wr_go) begin
            aw_held <= 1'b0;
            w_held <= 1'b0;
            s_axi_bvalid <= 1'b1;
            if (wr_hit_addr || wr_hit_cmd)
                s_axi_bresp <= `SBP_RESP_OKAY;
            else if (wr_addr == `SBP_REG_DATA)
                s_axi_bresp <= `SBP_RESP_SLVERR;
            else
                s_axi_bresp <= `SBP_RESP_DECERR;
        end else begin
            if (aw_fire) begin
                aw_held <= 1'b1;
                aw_addr <= s_axi_awaddr;
            end
            if (w_fire) begin
                w_held <= 1'b1;
                w_data <= s_axi_wdata;
                w_strb <= s_axi_wstrb;
            end
            if (s_axi_bvalid && s_axi_bready)
                s_axi_bvalid <= 1'b0;
        end
    end
end

// ------------------------------------------------------------
// read channel
// ------------------------------------------------------------
assign s_axi_arready = ~s_axi_rvalid;
wire ar_fire = s_axi_arvalid & s_axi_arready;
// the data register only streams once the opcode has been mirrored in
wire read_open = cmd_opcode == `SBP_READ_PARAM_OPCODE;
wire data_pop = ar_fire & (s_axi_araddr == `SBP_REG_DATA) & read_open;

always @(posedge aclk) begin
    if (!aresetn) begin
        s_axi_rvalid <= 1'b0;
        s_axi_rdata <= 32'h0000_0000;
        s_axi_rresp <= `SBP_RESP_OKAY;
    end else if (ar_fire) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rresp <= `SBP_RESP_OKAY;
        case (s_axi_araddr)
            `SBP_REG_ADDR: s_axi_rdata <= {{(32-ADDR_W){1'b0}}, rd_addr};
            `SBP_REG_DATA: s_axi_rdata <= {24'h000000, read_open ? rom_byte : `SBP_FILL_BYTE};
            `SBP_REG_CMD: s_axi_rdata <= {23'h000000, read_open, cmd_opcode};
            default: begin
                s_axi_rdata <= 32'h0000_0000;
                s_axi_rresp <= `SBP_RESP_DECERR;
            end
        endcase
    end else if (s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
    end
end

// ------------------------------------------------------------
// address pointer and command
// ------------------------------------------------------------
// a software write to the pointer in the same cycle as a pop wins,
// since the host is restarting the stream at a new place
always @(posedge aclk) begin
    if (!aresetn) begin
        rd_addr <= {ADDR_W{1'b0}};
        cmd_opcode <= 8'h00;
    end else begin
        if (wr_go && wr_hit_cmd && wr_strb[0])
            cmd_opcode <= wr_data[7:0];
        // a restart by opcode also beats a pop in the same cycle
        if (wr_go && wr_hit_addr && wr_strb[0])
            rd_addr <= wr_data[ADDR_W-1:0];
        else if (wr_go && wr_hit_cmd && wr_strb[0] && wr_data[7:0] == `SBP_READ_PARAM_OPCODE)
            rd_addr <= {ADDR_W{1'b0}};
        else if (data_pop)
            rd_addr <= rd_addr + {{(ADDR_W-1){1'b0}}, 1'b1};
    end
end

endmodule

// *** sbp_param_rom_monitor.sv ***
/* checker for the parameter table's axi4-lite port.
   assumes: bound to sbp_param_rom, one clock, synchronous reset. */
`timescale 1ns/1ns
module sbp_param_rom_monitor (
    input wire aclk,
    input wire aresetn,
    input wire s_axi_awvalid,
    input wire s_axi_awready,
    input wire s_axi_wvalid,
    input wire s_axi_wready,
    input wire [1:0] s_axi_bresp,
    input wire s_axi_bvalid,
    input wire s_axi_bready,
    input wire s_axi_arvalid,
    input wire s_axi_arready,
    input wire [31:0] s_axi_rdata,
    input wire s_axi_rvalid,
    input wire s_axi_rready
);
    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);
    a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read not answered");
    a_read_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read data moved");
    a_read_end: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
        else $error("read answer stuck");
    a_read_block: assert property (s_axi_rvalid |-> !s_axi_arready)
        else $error("read taken while busy");
    a_write_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |=> s_axi_bvalid)
        else $error("write not answered");
    a_write_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write response moved");
    a_write_end: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
        else $error("write response stuck");
    a_write_block: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
        else $error("write taken while busy");
endmodule
bind sbp_param_rom sbp_param_rom_monitor mon (.aclk(aclk), .aresetn(aresetn),
    .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready));

// *** sbp_host_model.sv ***
/* host model: axi4-lite master with random ready stalls.
   assumes: its tasks are entered just after a rising edge of aclk. */
`timescale 1ns/1ns
module sbp_host_model (
    input wire aclk,
    output reg [3:0] awaddr,
    output reg awvalid,
    input wire awready,
    output reg [31:0] wdata,
    output reg [3:0] wstrb,
    output reg wvalid,
    input wire wready,
    input wire bvalid,
    output reg bready,
    output reg [3:0] araddr,
    output reg arvalid,
    input wire arready,
    input wire rvalid,
    output reg rready
);
    reg pa, pw;
    initial begin
        {awaddr, araddr, wdata, wstrb} = 44'h0;
        {awvalid, wvalid, bready, arvalid, rready} = 5'h00;
    end
    // ready is read at the rising edge itself, before the slave's flops move
    task wr(input [3:0] a, input [31:0] d);
        begin
            awaddr <= a;
            wdata <= d;
            wstrb <= 4'hf;
            awvalid <= 1'b1;
            wvalid <= 1'b1;
            pa = 1'b1;
            pw = 1'b1;
            while (pa || pw) begin
                @(posedge aclk);
                if (pa && awready) begin
                    awvalid <= 1'b0;
                    pa = 1'b0;
                end
                if (pw && wready) begin
                    wvalid <= 1'b0;
                    pw = 1'b0;
                end
            end
            repeat ($urandom % 4) @(posedge aclk);
            bready <= 1'b1;
            @(posedge aclk);
            while (!bvalid) @(posedge aclk);
            bready <= 1'b0;
        end
    endtask
    task rd(input [3:0] a);
        begin
            araddr <= a;
            arvalid <= 1'b1;
            @(posedge aclk);
            while (!arready) @(posedge aclk);
            arvalid <= 1'b0;
            repeat ($urandom % 4) @(posedge aclk);
            rready <= 1'b1;
            @(posedge aclk);
            while (!rvalid) @(posedge aclk);
            rready <= 1'b0;
        end
    endtask
endmodule

// *** testbench.sv ***
/* self-checking bench: host model drives the table, a watcher compares answers.
   assumes: sbp_param_rom and sbp_host_model are compiled first. */
`timescale 1ns/1ns
module testbench;
    reg aclk = 1'b0;
    reg aresetn = 1'b0;
    wire [3:0] awaddr, wstrb, araddr;
    wire [31:0] wdata, rdata;
    wire [1:0] bresp, rresp;
    wire awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
    logic [33:0] rq[$];
    logic [1:0] bq[$];
    integer miscompares = 0;
    integer num_checks = 0;
    integer i;
    logic [7:0] p;
    logic [7:0] tbl [0:16] = '{8'he5, 8'h20, 8'hf1, 8'hff, 8'hff, 8'hff, 8'hff, 8'h00, 8'h44, 8'heb,
        8'h08, 8'h6b, 8'h08, 8'h3b, 8'h80, 8'hbb, 8'hee};
    always #4 aclk = ~aclk;
    sbp_param_rom dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
        .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
        .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready));
    sbp_host_model host (.aclk(aclk), .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
        .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bvalid(bvalid), .bready(bready),
        .araddr(araddr), .arvalid(arvalid), .arready(arready), .rvalid(rvalid), .rready(rready));
    task check_rd(input [33:0] got, input [33:0] exp);
        num_checks = num_checks + 1;
        if (got !== exp) begin
            miscompares = miscompares + 1;
            $display("BAD %0t read %h want %h", $time, got, exp);
        end
    endtask
    task check_wr(input [1:0] got, input [1:0] exp);
        num_checks = num_checks + 1;
        if (got !== exp) begin
            miscompares = miscompares + 1;
            $display("BAD %0t bresp %b want %b", $time, got, exp);
        end
    endtask
    always @(negedge aclk) begin
        if (rvalid && rready) check_rd({rresp, rdata}, rq.pop_front());
        if (bvalid && bready) check_wr(bresp, bq.pop_front());
    end
    task rd(input [3:0] a, input [1:0] r, input [31:0] d);
        rq.push_back({r, d});
        host.rd(a);
    endtask
    task wr(input [3:0] a, input [31:0] d, input [1:0] r);
        bq.push_back(r);
        host.wr(a, d);
    endtask
    task report_and_stop;
        $display("checks %0d miscompares %0d", num_checks, miscompares);
        if (miscompares == 0 && num_checks > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    initial begin
        #200000;
        miscompares = miscompares + 1;
        report_and_stop;
    end
    initial begin
        void'($urandom(18851));
        repeat (16) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        wr(4'h8, 32'h5a, 2'b00);
        rd(4'h8, 2'b00, 32'h15a);
        rd(4'h4, 2'b00, 32'hff);
        rd(4'h0, 2'b00, 32'h1);
        wr(4'h0, 32'h30, 2'b00);
        for (i = 0; i < 17; i++) rd(4'h4, 2'b00, {24'h0, tbl[i]});
        rd(4'h0, 2'b00, 32'h41);
        repeat (8) begin
            p = 8'h30 + 8'($urandom % 17);
            wr(4'h0, {24'h0, p}, 2'b00);
            rd(4'h4, 2'b00, {24'h0, tbl[p - 8'h30]});
        end
        wr(4'h8, 32'h11, 2'b00);
        rd(4'h4, 2'b00, 32'hff);
        rd(4'h0, 2'b00, {24'h0, p + 8'h1});
        wr(4'h4, 32'h0, 2'b10);
        wr(4'hc, 32'h0, 2'b11);
        rd(4'hc, 2'b11, 32'h0);
        report_and_stop;
    end
endmodule
